// >>> include/cscs_cfg.svh
`ifndef CSCS_CFG_SVH
`define CSCS_CFG_SVH

// Serial port targets, coded {direction, select bit 1, select bit 0}
`define CSCS_TGT_CLK_CFG 3'h0
`define CSCS_TGT_UART_CFG 3'h1
`define CSCS_TGT_UART_TX 3'h2
`define CSCS_TGT_PORT_EXT 3'h3
`define CSCS_TGT_UART_RX 3'h4
`define CSCS_TGT_UART_STAT 3'h5

// Reset values of the writable targets
`define CSCS_CLK_CFG_RST 8'h00
`define CSCS_PORT_EXT_RST 6'h00

// Clock configuration fields
`define CSCS_CC_CARD_LSB 0
`define CSCS_CC_CARD_MSB 4
`define CSCS_CC_CTRL_LSB 5
`define CSCS_CC_CTRL_MSB 7
`define CSCS_PICK_NONE 3'h5

// Card clock mux sources
`define CSCS_CK_XTAL_DIV2 3'h0
`define CSCS_CK_XTAL_DIV4 3'h1
`define CSCS_CK_XTAL_DIV8 3'h2
`define CSCS_CK_INT_DIV2 3'h3
`define CSCS_CK_STOP_HIGH 3'h4
`define CSCS_CK_STOP_LOW 3'h5

// Controller clock mux sources
`define CSCS_MC_INT_DIV8 2'h0
`define CSCS_MC_XTAL_DIV2 2'h1
`define CSCS_MC_XTAL_DIV4 2'h2
`define CSCS_MC_INT_DIV2 2'h3

// Sequencer step = internal oscillator divided by 2**this
`define CSCS_SEQ_DIV_LOG2 4

`endif

// >>> include/cscs_pkg.sv
package cscs_pkg;

  typedef enum logic [3:0] {
    CSCS_IDLE = 4'h0,
    CSCS_BOOST = 4'h1,
    CSCS_VCC = 4'h2,
    CSCS_IO = 4'h3,
    CSCS_ACTIVE = 4'h4,
    CSCS_D_RST = 4'h5,
    CSCS_D_CLK = 4'h6,
    CSCS_D_IO = 4'h7,
    CSCS_D_VCC = 4'h8,
    CSCS_D_BOOST = 4'h9
  } cscs_seq_t;

  typedef enum logic [1:0] {
    CSCS_RD_IDLE = 2'h0,
    CSCS_RD_LOADED = 2'h1,
    CSCS_RD_SHIFT = 2'h2
  } cscs_rd_t;

endpackage

// >>> rtl/cscs_top.sv
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "cscs_cfg.svh"
// Operation
// [RL1] Refuse session unless card present and supply fault pulse inactive.
// [RL2] In activation, card RST and CLK follow the reset control line; CLK starts on its rise but keeps running after it falls.
// [RL3] Session status line reports card presence.
// [RL4] In session, removal, supply drop or fault deactivates; status goes low.
// [RL5] Supervisor pulse ORed with external reset resets the controller.
// [RL6] Supervisor pulse keeps contacts inactive and forces deactivation.
// [RL7] Supervisor pulse drives open-drain output, polarity set at build time.
// [RL8] Contact hold released when supply rises, reapplied after boost stops.
// [RL9] Session request starts the boost converter first.
// [RL10] Sequencer steps on divided internal oscillator, not crystal.
// [RL11] After reset and in power reduction, controller clock is internal/8.
// [RL12] Controller may pick crystal/2, crystal/4 or internal/2.
// [RL13] Controller clock changes are glitch free.
// [RL14] Card clock: crystal/2,/4,/8, internal/2, stop high or stop low.
// [RL15] Card clock starts, stops and changes are glitch free.
// [RL16] After power-on card clock stops low, controller clock internal/8.
// [RL17] Power-down: card inactive; wake lines or card input change wakes.
// [RL18] Sleep: card powered, boost runs only to restore the rail.
// [RL19] Sequencer keeps running in both power reduction modes.
// [RL20] System controller selects internal clock before stopping the crystal.
// [RL21] Serial port reaches card UART, clock selection and port extension.
// [RL22] Write: select target, shift eight bits in on strobe rising edges.
// [RL23] Write: stage loads into target on enable falling edge.
// [RL24] Read: first enable pulse loads, second sets shift right, 7 shifts.
// [RL25] Wake compares inputs with values sampled on power reduction entry.
// [RL26] Clock mux switches only while old and new sources are low.

module cscs_clk_mux #(
  parameter int N = 4,
  parameter int SW = 2,
  parameter bit HAS_STOP_HIGH = 1'b0,
  parameter logic [SW-1:0] STOP_HIGH_IDX = '0,
  parameter logic [SW-1:0] RST_IDX = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Sources and selection
  input wire logic [N-1:0] src_i,
  input wire logic [SW-1:0] sel_i,
  // Muxed clock
  output logic clk_o
);
  logic [SW-1:0] cur;
  logic hold;
  wire change = (sel_i != cur);
  // A stopped-high source ends with a falling edge, so it counts as low
  wire cur_low = ~src_i[cur] | (HAS_STOP_HIGH && (cur == STOP_HIGH_IDX));
  wire new_low = ~src_i[sel_i] | (HAS_STOP_HIGH && (sel_i == STOP_HIGH_IDX));
  wire enter_hold = ~hold & change & cur_low;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cur <= RST_IDX;
      hold <= 1'b0;
    end
    else if (enter_hold)
      hold <= 1'b1; // [RL26]
    else if (hold && new_low)
    begin
      hold <= 1'b0;
      cur <= sel_i; // [RL26]
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      clk_o <= 1'b0;
    else
      clk_o <= (hold | enter_hold) ? 1'b0 : src_i[cur]; // [RL13] [RL15]
  end
endmodule

module cscs_top #(
  parameter int WAKE_W = 8,
  parameter bit CARD_INSERTED_INPUT_ACTIVE_HIGH = 1'b1,
  parameter bit ALARM_ACTIVE_HIGH = 1'b0,
  parameter int SEQ_DIV_LOG2 = `CSCS_SEQ_DIV_LOG2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Clock sources
  input wire logic crystal_input_i,
  input wire logic int_osc_i,
  // Supply supervisor and resets
  input wire logic supply_fault_pulse_i,
  input wire logic ext_reset_i,
  output logic controller_reset_o,
  output logic alarm_o,
  output logic alarm_oe_o,
  // Card side status
  input wire logic card_inserted_input_i,
  input wire logic hw_fault_i,
  input wire logic boost_rail_low_i,
  // Controller session lines
  input wire logic session_request_line_i,
  input wire logic reset_control_line_i,
  output logic session_status_port_bit_o,
  // Power reduction and wake
  input wire logic deep_power_save_i,
  input wire logic sleep_mode_i,
  input wire logic [WAKE_W-1:0] wake_port_lines_i,
  output logic wake_o,
  // Card contacts and supply control
  output logic boost_en_o,
  output logic vcc_en_o,
  output logic contact_hold_supply_o,
  output logic card_io_en_o,
  output logic card_rst_o,
  output logic card_clk_o,
  // Controller clock
  output logic ctrl_clk_o,
  // Serial peripheral port
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  input wire logic serial_strobe_i,
  input wire logic serial_enable_i,
  input wire logic target_select_bit0_i,
  input wire logic target_select_bit1_i,
  input wire logic serial_dir_i,
  // Card UART access
  output logic uart_cfg_wr_o,
  output logic uart_tx_wr_o,
  output logic [7:0] uart_wdata_o,
  output logic uart_rx_rd_o,
  input wire logic [7:0] uart_rx_data_i,
  input wire logic [7:0] uart_status_i,
  // Port extension
  output logic [5:0] ext_port_o
);
  localparam int I_XTAL = 0;
  localparam int I_OSC = 1;
  localparam int I_CARD_INSERTED_INPUT = 2;
  localparam int I_FAULT = 3;
  localparam int I_EXTRST = 4;
  localparam int I_HWF = 5;
  localparam int I_REQ = 6;
  localparam int I_RSTC = 7;
  localparam int I_PD = 8;
  localparam int I_SLEEP = 9;
  localparam int I_RAIL = 10;
  localparam int I_DATA = 11;
  localparam int I_STB = 12;
  localparam int I_EN = 13;
  localparam int I_SEL0 = 14;
  localparam int I_SEL1 = 15;
  localparam int I_RW = 16;
  localparam int NA = 17 + WAKE_W;
  // Strobe and enable idle high; resetting them low would fake an edge
  localparam logic [NA-1:0] SYNC_IDLE = (NA'(1) << I_STB) | (NA'(1) << I_EN);

  // Picks the lowest set bit of a 5-bit mask, none gives PICK_NONE
  function automatic logic [2:0] cscs_pick(input logic [4:0] m);
    logic [2:0] r;
    r = `CSCS_PICK_NONE;
    for (int i = 4; i >= 0; i--)
      if (m[i])
        r = 3'(i);
    return r;
  endfunction

  // Input synchronisers; stage 3 only serves edge detection
  wire [NA-1:0] ain = {wake_port_lines_i, serial_dir_i, target_select_bit1_i,
    target_select_bit0_i, serial_enable_i, serial_strobe_i, serial_data_i,
    boost_rail_low_i, sleep_mode_i, deep_power_save_i, reset_control_line_i,
    session_request_line_i, hw_fault_i, ext_reset_i, supply_fault_pulse_i,
    card_inserted_input_i, int_osc_i, crystal_input_i};
  logic [NA-1:0] s1;
  logic [NA-1:0] s2;
  logic [NA-1:0] s3;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s1 <= SYNC_IDLE;
      s2 <= SYNC_IDLE;
      s3 <= SYNC_IDLE;
    end
    else
    begin
      s1 <= ain;
      s2 <= s1;
      s3 <= s2;
    end
  end

  wire card_present = (s2[I_CARD_INSERTED_INPUT] == CARD_INSERTED_INPUT_ACTIVE_HIGH);
  wire fault = s2[I_FAULT];
  wire power_down = s2[I_PD];
  wire power_reduced = s2[I_PD] | s2[I_SLEEP];
  wire card_reset_drive_request = s2[I_RSTC];
  wire [WAKE_W-1:0] wake_now = s2[NA-1:17];

  // Clock dividers on synchronised source edges
  wire xtal_rise = s2[I_XTAL] & ~s3[I_XTAL];
  wire osc_rise = s2[I_OSC] & ~s3[I_OSC];
  logic [2:0] xtal_cnt;
  logic [SEQ_DIV_LOG2-1:0] int_cnt;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      xtal_cnt <= 3'h0;
      int_cnt <= '0;
    end
    else
    begin
      xtal_cnt <= xtal_cnt + 3'(xtal_rise);
      int_cnt <= int_cnt + SEQ_DIV_LOG2'(osc_rise);
    end
  end

  wire seq_tick = osc_rise & (&int_cnt); // [RL10] [RL19]

  // Serial port decode
  wire sp_rw = s2[I_RW];
  wire [2:0] sp_tgt = {s2[I_RW], s2[I_SEL1], s2[I_SEL0]};
  wire stb_rise = s2[I_STB] & ~s3[I_STB];
  wire en_fall = ~s2[I_EN] & s3[I_EN];
  wire en_rise = s2[I_EN] & ~s3[I_EN];
  cscs_pkg::cscs_rd_t rd_phase;
  logic [7:0] stage;
  logic [7:0] clk_cfg;
  logic [5:0] port_ext;
  wire [7:0] read_val = (sp_tgt == `CSCS_TGT_UART_RX) ? uart_rx_data_i :
    (sp_tgt == `CSCS_TGT_UART_STAT) ? uart_status_i : 8'h00;
  wire wr_load = en_fall & ~sp_rw;
  wire rd_load = en_rise & sp_rw & (rd_phase != cscs_pkg::CSCS_RD_LOADED);

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      stage <= 8'h00;
    else if (rd_load)
      stage <= read_val; // [RL24]
    else if (stb_rise && !sp_rw)
      stage <= {s2[I_DATA], stage[7:1]}; // [RL22]
    else if (stb_rise && rd_phase == cscs_pkg::CSCS_RD_SHIFT)
      stage <= {1'b0, stage[7:1]}; // [RL24]
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i || !sp_rw)
      rd_phase <= cscs_pkg::CSCS_RD_IDLE;
    else if (rd_load)
      rd_phase <= cscs_pkg::CSCS_RD_LOADED;
    else if (en_rise)
      rd_phase <= cscs_pkg::CSCS_RD_SHIFT; // [RL24]
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      clk_cfg <= `CSCS_CLK_CFG_RST;
      port_ext <= `CSCS_PORT_EXT_RST;
      uart_wdata_o <= 8'h00;
    end
    else if (wr_load)
    begin
      if (sp_tgt == `CSCS_TGT_CLK_CFG)
        clk_cfg <= stage; // [RL23] [RL21]
      if (sp_tgt == `CSCS_TGT_PORT_EXT)
        port_ext <= stage[5:0]; // [RL23] [RL21]
      uart_wdata_o <= stage;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      uart_cfg_wr_o <= 1'b0;
      uart_tx_wr_o <= 1'b0;
      uart_rx_rd_o <= 1'b0;
    end
    else
    begin
      uart_cfg_wr_o <= wr_load & (sp_tgt == `CSCS_TGT_UART_CFG); // [RL21]
      uart_tx_wr_o <= wr_load & (sp_tgt == `CSCS_TGT_UART_TX);
      uart_rx_rd_o <= rd_load & (sp_tgt == `CSCS_TGT_UART_RX);
    end
  end

  assign serial_data_o = stage[0];
  assign serial_data_oe_o = sp_rw & (rd_phase == cscs_pkg::CSCS_RD_SHIFT);
  assign ext_port_o = ~port_ext;

  // Activation and deactivation sequencer
  cscs_pkg::cscs_seq_t state;
  cscs_pkg::cscs_seq_t next_state;
  logic emerg_hold;
  wire req = s2[I_REQ];
  wire emergency = ~card_present | fault | s2[I_HWF] | power_down; // [RL4] [RL6] [RL17]
  wire in_session = (state == cscs_pkg::CSCS_BOOST) || (state == cscs_pkg::CSCS_VCC) ||
    (state == cscs_pkg::CSCS_IO) || (state == cscs_pkg::CSCS_ACTIVE);
  wire start_ok = req & card_present & ~fault & ~power_down & ~emerg_hold; // [RL1]

  always_comb
  begin
    next_state = state;
    unique case (state)
      cscs_pkg::CSCS_IDLE:
        if (start_ok)
          next_state = cscs_pkg::CSCS_BOOST; // [RL9]
      cscs_pkg::CSCS_BOOST,
      cscs_pkg::CSCS_VCC,
      cscs_pkg::CSCS_IO,
      cscs_pkg::CSCS_ACTIVE:
        if (emergency || !req)
          next_state = cscs_pkg::CSCS_D_RST; // [RL4]
        else if (state != cscs_pkg::CSCS_ACTIVE)
          next_state = cscs_pkg::cscs_seq_t'(state + 4'h1);
      cscs_pkg::CSCS_D_RST,
      cscs_pkg::CSCS_D_CLK,
      cscs_pkg::CSCS_D_IO,
      cscs_pkg::CSCS_D_VCC:
        next_state = cscs_pkg::cscs_seq_t'(state + 4'h1);
      cscs_pkg::CSCS_D_BOOST:
        next_state = cscs_pkg::CSCS_IDLE;
      default:
        next_state = cscs_pkg::CSCS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      state <= cscs_pkg::CSCS_IDLE;
    else if (seq_tick)
      state <= next_state; // [RL10] [RL19]
  end

  // Emergency latch holds status low until the request is withdrawn
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      emerg_hold <= 1'b0;
    else if (seq_tick && in_session && emergency)
      emerg_hold <= 1'b1; // [RL4]
    else if (!req)
      emerg_hold <= 1'b0;
  end

  wire st_vcc_on = (state == cscs_pkg::CSCS_VCC) || (state == cscs_pkg::CSCS_IO) ||
    (state == cscs_pkg::CSCS_ACTIVE) || (state == cscs_pkg::CSCS_D_RST) ||
    (state == cscs_pkg::CSCS_D_CLK) || (state == cscs_pkg::CSCS_D_IO);
  wire st_boost = st_vcc_on || (state == cscs_pkg::CSCS_BOOST) ||
    (state == cscs_pkg::CSCS_D_VCC);
  wire st_io = (state == cscs_pkg::CSCS_IO) || (state == cscs_pkg::CSCS_ACTIVE) ||
    (state == cscs_pkg::CSCS_D_RST) || (state == cscs_pkg::CSCS_D_CLK);
  wire st_active = (state == cscs_pkg::CSCS_ACTIVE);
  logic clk_armed;

  // Card clock waits for the reset control line, so no pulse escapes the count
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      clk_armed <= 1'b0;
    else if (st_active && card_reset_drive_request)
      clk_armed <= 1'b1; // [RL2]
    else if (!st_active && state != cscs_pkg::CSCS_D_RST)
      clk_armed <= 1'b0;
  end

  wire st_clk_run = clk_armed & (st_active || (state == cscs_pkg::CSCS_D_RST)); // [RL2]
  wire sleep_only = s2[I_SLEEP] & st_active;
  wire next_boost = sleep_only ? s2[I_RAIL] : st_boost; // [RL18]
  wire next_rst = st_active & card_reset_drive_request & ~fault; // [RL2] [RL6]

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      boost_en_o <= 1'b0;
      vcc_en_o <= 1'b0;
      contact_hold_supply_o <= 1'b1;
      card_io_en_o <= 1'b0;
      card_rst_o <= 1'b0;
      session_status_port_bit_o <= 1'b0;
    end
    else
    begin
      boost_en_o <= next_boost; // [RL9] [RL18]
      vcc_en_o <= st_vcc_on;
      contact_hold_supply_o <= ~(st_vcc_on | (state == cscs_pkg::CSCS_D_VCC)); // [RL8]
      card_io_en_o <= st_io;
      card_rst_o <= next_rst; // [RL2]
      session_status_port_bit_o <= card_present & ~emerg_hold; // [RL3] [RL4]
    end
  end

  // Supervisor pulse to controller reset and open-drain alarm pin
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      controller_reset_o <= 1'b1;
      alarm_oe_o <= 1'b0;
    end
    else
    begin
      controller_reset_o <= fault | s2[I_EXTRST]; // [RL5]
      alarm_oe_o <= ALARM_ACTIVE_HIGH ? ~fault : fault; // [RL7]
    end
  end

  assign alarm_o = 1'b0;

  // Wake detection against values caught on entry to power reduction
  logic pr_d;
  logic [WAKE_W:0] wake_snap;
  wire [WAKE_W:0] wake_cur = {card_present, wake_now};

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pr_d <= 1'b0;
      wake_snap <= '0;
      wake_o <= 1'b0;
    end
    else
    begin
      pr_d <= power_reduced;
      if (power_reduced && !pr_d)
        wake_snap <= wake_cur; // [RL25]
      wake_o <= power_reduced & pr_d & (wake_cur != wake_snap); // [RL17] [RL25]
    end
  end

  // Clock selection
  wire [2:0] card_pick = cscs_pick(clk_cfg[`CSCS_CC_CARD_MSB:`CSCS_CC_CARD_LSB]);
  wire [2:0] ctrl_pick = cscs_pick({2'b00, clk_cfg[`CSCS_CC_CTRL_MSB:`CSCS_CC_CTRL_LSB]});
  wire [2:0] card_sel = !st_clk_run ? `CSCS_CK_STOP_LOW :
    (card_pick == `CSCS_PICK_NONE) ? `CSCS_CK_STOP_LOW : card_pick; // [RL14] [RL16] [RL2]
  wire [1:0] ctrl_sel = (power_reduced || ctrl_pick == `CSCS_PICK_NONE) ?
    `CSCS_MC_INT_DIV8 : 2'(ctrl_pick + 3'h1); // [RL11] [RL12] [RL16]
  wire [7:0] card_src = {2'b00, 1'b0, 1'b1, int_cnt[0], xtal_cnt[2], xtal_cnt[1],
    xtal_cnt[0]};
  wire [3:0] ctrl_src = {int_cnt[0], xtal_cnt[1], xtal_cnt[0], int_cnt[2]};

  cscs_clk_mux #(
    .N(8),
    .SW(3),
    .HAS_STOP_HIGH(1'b1),
    .STOP_HIGH_IDX(`CSCS_CK_STOP_HIGH),
    .RST_IDX(`CSCS_CK_STOP_LOW)
  ) u_card_mux (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .src_i(card_src),
    .sel_i(card_sel),
    .clk_o(card_clk_o)
  );

  cscs_clk_mux #(
    .N(4),
    .SW(2),
    .HAS_STOP_HIGH(1'b0),
    .STOP_HIGH_IDX(2'h0),
    .RST_IDX(`CSCS_MC_INT_DIV8)
  ) u_ctrl_mux (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .src_i(ctrl_src),
    .sel_i(ctrl_sel),
    .clk_o(ctrl_clk_o)
  );
endmodule

// >>> test/cscs_ctrl_model.sv
`timescale 1ns/1ps
module cscs_ctrl_model #(
  parameter logic [7:0] RX_BYTE = 8'h00,
  parameter logic [7:0] STAT_BYTE = 8'h00
) (
  // Clock and serial line
  input wire logic clock_i,
  input wire logic line_i,
  // Controller pins
  output logic drv_oe_o,
  output logic drv_o,
  output logic strobe_o,
  output logic enable_o,
  output logic sel0_o,
  output logic sel1_o,
  output logic dir_o,
  // Card UART side
  output logic [7:0] rx_o,
  output logic [7:0] stat_o
);
  assign rx_o = RX_BYTE;
  assign stat_o = STAT_BYTE;
  initial
  begin
    drv_oe_o = 1'b0;
    drv_o = 1'b1;
    strobe_o = 1'b1;
    enable_o = 1'b1;
    {dir_o, sel1_o, sel0_o} = 3'h0;
  end
  // Five clocks per level so the pin synchronisers catch it
  task automatic hold_pins();
    repeat (5) @(posedge clock_i);
  endtask
  task automatic pick(input logic [2:0] tgt);
    @(posedge clock_i);
    {dir_o, sel1_o, sel0_o} <= tgt;
    hold_pins();
  endtask
  task automatic pulse(input bit st);
    if (st)
      strobe_o <= 1'b0;
    else
      enable_o <= 1'b0;
    hold_pins();
    if (st)
      strobe_o <= 1'b1;
    else
      enable_o <= 1'b1;
    hold_pins();
  endtask
  task automatic ser_write(input logic [2:0] tgt, input logic [7:0] d);
    pick(tgt);
    drv_oe_o <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      drv_o <= d[i];
      pulse(1'b1);
    end
    pulse(1'b0);
    drv_oe_o <= 1'b0;
  endtask
  task automatic ser_read(input logic [2:0] tgt, output logic [7:0] d);
    pick(tgt);
    pulse(1'b0);
    pulse(1'b0);
    d[0] = line_i;
    for (int i = 1; i < 8; i++)
    begin
      pulse(1'b1);
      d[i] = line_i;
    end
    pick(3'h0);
  endtask
endmodule

// >>> test/cscs_top_asserts.sv
`timescale 1ns/1ps
module cscs_chk #(
  parameter int WAKE_W = 8,
  parameter bit CARD_INSERTED_INPUT_ACTIVE_HIGH = 1'b1,
  parameter bit ALARM_ACTIVE_HIGH = 1'b0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Supervisor and resets
  input wire logic supply_fault_pulse_i,
  input wire logic ext_reset_i,
  input wire logic controller_reset_o,
  input wire logic alarm_o,
  input wire logic alarm_oe_o,
  // Card and wake
  input wire logic card_inserted_input_i,
  input wire logic deep_power_save_i,
  input wire logic [WAKE_W-1:0] wake_port_lines_i,
  input wire logic wake_o,
  // Contacts
  input wire logic boost_en_o,
  input wire logic vcc_en_o,
  input wire logic contact_hold_supply_o,
  input wire logic card_io_en_o,
  input wire logic card_rst_o
);
  logic card_inserted_input;
  assign card_inserted_input = (card_inserted_input_i == CARD_INSERTED_INPUT_ACTIVE_HIGH);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_refuse_start: assert property (
    (!card_inserted_input || supply_fault_pulse_i) [*8] |-> !$rose(boost_en_o))
    else $error("boost started while refused");
  a_boost_first: assert property (
    $rose(vcc_en_o) |-> boost_en_o && $past(boost_en_o))
    else $error("supply before boost");
  a_hold_vcc: assert property (
    vcc_en_o |-> !contact_hold_supply_o)
    else $error("hold applied with supply on");
  a_hold_back: assert property (
    $fell(boost_en_o) && !vcc_en_o |-> contact_hold_supply_o)
    else $error("hold not back after boost stop");
  a_rst_contacts: assert property (
    card_rst_o |-> card_io_en_o && vcc_en_o)
    else $error("card reset outside session");
  a_reset_or: assert property (
    (supply_fault_pulse_i || ext_reset_i) [*4] |-> controller_reset_o)
    else $error("controller reset missing");
  a_alarm_drive: assert property (
    supply_fault_pulse_i [*4] |-> alarm_oe_o == !ALARM_ACTIVE_HIGH && !alarm_o)
    else $error("alarm pin wrong");
  a_emerg_deact: assert property (
    vcc_en_o && $fell(card_inserted_input) |-> ##[1:800] !vcc_en_o)
    else $error("no emergency deactivation");
  a_wake_flag: assert property (
    deep_power_save_i [*8] ##1 (deep_power_save_i && $changed(wake_port_lines_i))
    |-> ##[1:8] wake_o)
    else $error("wake not flagged");
  c_session: cover property ($rose(vcc_en_o));
  c_wake: cover property ($rose(wake_o));
  c_emerg: cover property (vcc_en_o && $fell(card_inserted_input));
endmodule

bind cscs_top cscs_chk #(
  .WAKE_W(WAKE_W),
  .CARD_INSERTED_INPUT_ACTIVE_HIGH(CARD_INSERTED_INPUT_ACTIVE_HIGH),
  .ALARM_ACTIVE_HIGH(ALARM_ACTIVE_HIGH)
) cscs_chk_i (.*);

// >>> test/tb_top.sv
`timescale 1ns/1ps
`include "cscs_cfg.svh"
module tb_top;
  typedef struct packed {logic [2:0] tgt; logic [7:0] din; logic [7:0] exp;} cscs_row_t;
  localparam logic [7:0] RX = 8'hA5;
  localparam logic [7:0] ST = 8'h13;
  localparam cscs_row_t ROWS [6] = '{'{`CSCS_TGT_UART_TX, 8'h96, 8'h96},
    '{`CSCS_TGT_UART_CFG, 8'h0B, 8'h0B}, '{`CSCS_TGT_PORT_EXT, 8'h2C, 8'h13},
    '{`CSCS_TGT_UART_RX, 8'h00, RX}, '{`CSCS_TGT_UART_STAT, 8'h00, ST},
    '{3'h6, 8'h00, 8'h00}};
  logic clock_i = 1'b0, rst_i = 1'b1, crystal_input_i = 1'b0, int_osc_i = 1'b0;
  logic xtal_run = 1'b1, supply_fault_pulse_i = 1'b0, ext_reset_i = 1'b0;
  logic card_inserted_input_i = 1'b0, hw_fault_i = 1'b0, boost_rail_low_i = 1'b0;
  logic session_request_line_i = 1'b0, reset_control_line_i = 1'b0;
  logic deep_power_save_i = 1'b0, sleep_mode_i = 1'b0;
  logic [7:0] wake_port_lines_i = 8'h00;
  logic controller_reset_o, alarm_o, alarm_oe_o, session_status_port_bit_o, wake_o;
  logic boost_en_o, vcc_en_o, contact_hold_supply_o, card_io_en_o, card_rst_o;
  logic card_clk_o, ctrl_clk_o, serial_data_o, serial_data_oe_o;
  logic uart_cfg_wr_o, uart_tx_wr_o, uart_rx_rd_o;
  logic [7:0] uart_wdata_o, wr_seen, rd;
  logic [5:0] ext_port_o;
  logic [1:0] wr_kind;
  wire logic serial_data_i, serial_strobe_i, serial_enable_i, m_oe, m_dat;
  wire logic target_select_bit0_i, target_select_bit1_i, serial_dir_i;
  wire logic [7:0] uart_rx_data_i, uart_status_i;
  int error_cnt = 0, samples_checked = 0, nc, nm, rx_pulses = 0;
  // Shared data line with pull-up
  assign serial_data_i = serial_data_oe_o ? serial_data_o : (m_oe ? m_dat : 1'b1);
  always #2 clock_i = ~clock_i;
  always #16 int_osc_i = ~int_osc_i;
  always #12 if (xtal_run) crystal_input_i = ~crystal_input_i;
  always @(posedge clock_i)
    if (uart_tx_wr_o || uart_cfg_wr_o)
    begin
      wr_seen <= uart_wdata_o;
      wr_kind <= {uart_cfg_wr_o, uart_tx_wr_o};
    end
  cscs_top cscs_top_i (.*);
  always @(posedge clock_i)
    if (uart_rx_rd_o)
      rx_pulses <= rx_pulses + 1;
  cscs_ctrl_model #(.RX_BYTE(RX), .STAT_BYTE(ST)) cscs_ctrl_model_i (.clock_i(clock_i),
    .line_i(serial_data_i), .drv_oe_o(m_oe), .drv_o(m_dat), .strobe_o(serial_strobe_i),
    .enable_o(serial_enable_i), .sel0_o(target_select_bit0_i),
    .sel1_o(target_select_bit1_i), .dir_o(serial_dir_i), .rx_o(uart_rx_data_i),
    .stat_o(uart_status_i));
  task automatic final_report();
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return boost_en_o;
      1: return vcc_en_o;
      2: return card_io_en_o;
      default: return wake_o;
    endcase
  endfunction
  task automatic wait_on(input int k, input logic v);
    int n;
    n = 0;
    while (sig(k) !== v && n < 2000)
    begin
      @(posedge clock_i);
      n++;
    end
    chk("wait", v, sig(k));
    if (n >= 2000)
      final_report();
  endtask
  // Rising edges of card and controller clocks over a window
  task automatic count(input int cyc);
    logic pc, pm;
    nc = 0;
    nm = 0;
    pc = card_clk_o;
    pm = ctrl_clk_o;
    repeat (cyc)
    begin
      @(posedge clock_i);
      nc += int'(card_clk_o === 1'b1 && pc === 1'b0);
      nm += int'(ctrl_clk_o === 1'b1 && pm === 1'b0);
      pc = card_clk_o;
      pm = ctrl_clk_o;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  initial
  begin
    idle(3);
    rst_i <= 1'b0;
    idle(2);
    chk("hold", 1, contact_hold_supply_o);
    count(256);
    chk("ctrl_div8", 1, nm >= 3 && nm <= 5);
    chk("card_stop", 0, nc | card_clk_o);
    ext_reset_i <= 1'b1;
    idle(6);
    chk("ctl_rst", 1, controller_reset_o);
    ext_reset_i <= 1'b0;
    idle(8);
    chk("ctl_rst", 0, controller_reset_o);
    $display("test reset done");
    for (int r = 0; r < 6; r++)
    begin
      if (ROWS[r].tgt[2])
      begin
        cscs_ctrl_model_i.ser_read(ROWS[r].tgt, rd);
        chk("read", ROWS[r].exp, rd);
      end
      else
      begin
        cscs_ctrl_model_i.ser_write(ROWS[r].tgt, ROWS[r].din);
        if (ROWS[r].tgt == `CSCS_TGT_PORT_EXT)
          chk("port_ext", ROWS[r].exp, {2'h0, ext_port_o});
        else
          chk("wdata", ROWS[r].exp, wr_seen);
        if (ROWS[r].tgt != `CSCS_TGT_PORT_EXT)
          chk("kind", ROWS[r].tgt == `CSCS_TGT_UART_TX ? 1 : 2, wr_kind);
      end
    end
    chk("rx_rd", 1, 8'(rx_pulses));
    $display("test serial rows done");
    cscs_ctrl_model_i.ser_write(`CSCS_TGT_CLK_CFG, 8'h21);
    idle(48);
    count(96);
    chk("ctrl_xtal2", 1, nm >= 7 && nm <= 9);
    session_request_line_i <= 1'b1;
    idle(300);
    chk("no_card", 0, boost_en_o);
    chk("status", 0, session_status_port_bit_o);
    card_inserted_input_i <= 1'b1;
    supply_fault_pulse_i <= 1'b1;
    idle(300);
    chk("fault", 0, boost_en_o);
    chk("alarm_oe", 1, alarm_oe_o);
    supply_fault_pulse_i <= 1'b0;
    session_request_line_i <= 1'b0;
    idle(20);
    chk("status", 1, session_status_port_bit_o);
    session_request_line_i <= 1'b1;
    wait_on(0, 1'b1);
    chk("vcc_late", 0, vcc_en_o);
    wait_on(1, 1'b1);
    chk("hold_off", 0, contact_hold_supply_o);
    wait_on(2, 1'b1);
    idle(200);
    count(48);
    chk("clk_wait", 0, 8'(nc));
    reset_control_line_i <= 1'b1;
    idle(24);
    count(96);
    chk("card_rst", 1, card_rst_o);
    chk("card_xtal2", 1, nc >= 7 && nc <= 9);
    reset_control_line_i <= 1'b0;
    idle(10);
    chk("card_rst", 0, card_rst_o);
    sleep_mode_i <= 1'b1;
    idle(8);
    chk("sleep_boost", 0, boost_en_o);
    chk("sleep_vcc", 1, vcc_en_o);
    boost_rail_low_i <= 1'b1;
    idle(8);
    chk("rail_boost", 1, boost_en_o);
    {sleep_mode_i, boost_rail_low_i} <= 2'h0;
    idle(8);
    $display("test activation done");
    card_inserted_input_i <= 1'b0;
    idle(6);
    chk("status", 0, session_status_port_bit_o);
    wait_on(1, 1'b0);
    wait_on(0, 1'b0);
    idle(2);
    chk("hold_on", 1, contact_hold_supply_o);
    card_inserted_input_i <= 1'b1;
    idle(300);
    chk("relatch", 0, boost_en_o);
    session_request_line_i <= 1'b0;
    $display("test emergency done");
    cscs_ctrl_model_i.ser_write(`CSCS_TGT_CLK_CFG, 8'h00);
    idle(16);
    xtal_run <= 1'b0;
    deep_power_save_i <= 1'b1;
    count(256);
    chk("pd_div8", 1, nm >= 3 && nm <= 5);
    wake_port_lines_i <= 8'h04;
    wait_on(3, 1'b1);
    $display("test power down done");
    final_report();
  end
endmodule
